/* design/bpt_regs.vh */
// constants for the buffered pwm timer channel block
`ifndef BPT_REGS_VH
`define BPT_REGS_VH
`define BPT_NCH 6
`define BPT_CW 16
`define BPT_MOD_RST 16'hffff
`define BPT_CNT_RST 16'h0000
`define BPT_MODE_UNBUF 2'h1
`define BPT_MODE_BUF 2'h2
`define BPT_ELS_CLEAR 2'h2
`define BPT_ELS_SET 2'h3
`define BPT_ELS_TOGGLE 2'h1
`endif

/* design/bpt_timer.v */
// six-channel timer with buffered and unbuffered pwm
`timescale 1ns/1ps
`include "bpt_regs.vh"

module bpt_timer
(
    // clock, reset, enable
    input wire clk_sys_i,
    input wire rstn_i,
    input wire clk_en_i,
    // system state
    input wire wait_mode_i,
    input wire stop_mode_i,
    input wire break_active_i,
    input wire break_clear_permit_i,
    // timer control
    input wire counter_halt_i,
    input wire counter_clear_i,
    input wire [2:0] prescale_sel_i,
    input wire wrap_irq_enable_i,
    input wire [15:0] modulo_value_i,
    input wire modulo_wr_i,
    // wrap flag two-step clear
    input wire wrap_flag_rd_i,
    input wire wrap_flag_clr_i,
    // per-channel control, packed channel 0 in low bits
    input wire [5:0] buffer_link_select_i,
    input wire [5:0] unbuffered_mode_select_i,
    input wire [11:0] edge_level_select_i,
    input wire [5:0] toggle_on_wrap_i,
    input wire [5:0] full_duty_select_i,
    input wire [5:0] channel_irq_enable_i,
    // compare value write port
    input wire cmp_wr_i,
    input wire [2:0] cmp_ch_i,
    input wire [15:0] cmp_data_i,
    // channel flag two-step clear
    input wire [5:0] ch_flag_rd_i,
    input wire [5:0] ch_flag_clr_i,
    // outputs
    output wire [15:0] counter_o,
    output wire counter_wrap_flag_o,
    output wire [5:0] channel_event_flag_o,
    output wire [5:0] channel_pin_o,
    output wire [5:0] channel_pin_oe_o,
    output wire [2:0] active_set_o,
    output wire irq_o,
    output wire wake_o
);

    //------------------------------------------------------------
    // behaviour notes
    //------------------------------------------------------------
    // all state advances only on edges where clk_en_i is high and
    // stop mode is off, so a frozen block resumes exactly where it
    // stopped, counter and pins included.
    // the counter counts from zero up to the modulo value and wraps
    // to zero on the following tick; the period is modulo plus one.
    // a compare match and a wrap both need a counter tick, so a
    // halted counter produces no flags and no pin edges, except a full duty pin parked at pulse level.
    // pulse width runs from the wrap to the compare match: the wrap
    // toggles the pin into its pulse level and the match forces the
    // complement of that level.
    // a linked pair keeps its even channel's controls; the odd
    // channel loses its pin enable so the pin can serve as plain io.
    // the set in use changes only at a wrap, never mid-period, which
    // is what keeps a buffered width update glitch free.
    // software that writes the set in use gets unbuffered behaviour;
    // the block cannot guard against that and does not try.
    // toggle on compare is decoded, but it can drift out of phase
    // after noise and cannot give a reliable zero duty; it stays in
    // only for plain output compare use.
    // when a compare and a wrap fall in one cycle the compare wins;
    // full duty, set together with the wrap toggle, wins over both
    // and parks the pin at pulse level.
    // flag clears take two steps, a read with the flag set and then
    // a clear; a new event between the steps spoils the armed read,
    // so a pending interrupt request is never lost.
    // in wait mode the bus is cut off: compare and modulo writes, flag reads
    // and flag clears are ignored; counter clear still acts and the counter keeps running.
    // in a debug break the counter and prescaler hold unless counter clear zeroes them,
    // and flag clears only act when the break clear permit is high.
    // prescaler select seven names an external clock that this block
    // does not serve; the counter simply stops there.
    // between the two byte writes of the modulo value the wrap flag
    // cannot set, so a half-written period raises no request.

    //------------------------------------------------------------
    // state
    //------------------------------------------------------------
    reg [15:0] cnt_ff; // main counter
    reg [6:0] pre_ff; // prescaler
    reg [15:0] cmp_ff [0:5]; // compare values
    reg [5:0] pin_ff; // channel outputs
    reg [2:0] last_odd_ff; // last written set per pair is odd
    reg [2:0] act_odd_ff; // set in use this period is odd
    reg wrap_flag_ff; // wrap flag
    reg wrap_arm_ff; // first clear step seen
    reg [5:0] ch_flag_ff; // channel event flags
    reg [5:0] ch_arm_ff; // first clear step seen per channel
    reg mod_lock_ff; // modulo write in progress blocks wrap flag
    integer i; // loop index, combinational decode only
    integer j; // loop index, counter block only
    integer k; // loop index, pin block only
    integer m; // loop index, flag block only

    // core advances only when enabled and not stopped
    wire run = clk_en_i & ~stop_mode_i;
    // registers cannot be reached from the bus in wait mode
    wire acc = ~wait_mode_i;
    // flag clears blocked in break unless permitted
    wire clr_ok = acc & (~break_active_i | break_clear_permit_i);

    //------------------------------------------------------------
    // prescaler tick
    //------------------------------------------------------------
    reg tick;
    always @*
    begin
        case (prescale_sel_i)
            3'h0: tick = 1'b1;
            3'h1: tick = pre_ff[0];
            3'h2: tick = &pre_ff[1:0];
            3'h3: tick = &pre_ff[2:0];
            3'h4: tick = &pre_ff[3:0];
            3'h5: tick = &pre_ff[4:0];
            3'h6: tick = &pre_ff[5:0];
            default: tick = 1'b0; // external clock source is not served here
        endcase
    end

    // counter steps only when not halted and not in break
    wire go = ~counter_halt_i & ~break_active_i;
    wire step = go & tick;
    wire wrap = step & (cnt_ff == modulo_value_i);

    //------------------------------------------------------------
    // per-channel effective mode
    //------------------------------------------------------------
    reg [5:0] linked; // odd channel absorbed into a pair
    reg [5:0] out_mode; // channel drives its pin as output compare
    reg [5:0] match;
    reg [15:0] cmp_sel;
    always @*
    begin
        linked = 6'h00;
        out_mode = 6'h00;
        match = 6'h00;
        cmp_sel = 16'h0000;
        for (i = 0; i < 6; i = i + 1)
        begin
            if (i % 2 == 0)
            begin
                // link bit wins over unbuffered bit
                // either mode code (01 plain, 10 buffered) makes an output
                out_mode[i] = buffer_link_select_i[i] | unbuffered_mode_select_i[i];
                if (buffer_link_select_i[i])
                begin
                    linked[i + 1] = 1'b1;
                    // even set first, then the set chosen at wrap
                    cmp_sel = act_odd_ff[i / 2] ? cmp_ff[i + 1] : cmp_ff[i];
                end
                else
                begin
                    cmp_sel = cmp_ff[i];
                end
            end
            else
            begin
                cmp_sel = cmp_ff[i];
            end
            match[i] = step & (cnt_ff == cmp_sel);
        end
        for (i = 1; i < 6; i = i + 2)
        begin
            // odd control is void while linked
            out_mode[i] = unbuffered_mode_select_i[i] & ~linked[i];
        end
    end

    //------------------------------------------------------------
    // counter, prescaler, compare storage and pair selection
    //------------------------------------------------------------
    always @(posedge clk_sys_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            cnt_ff <= `BPT_CNT_RST;
            pre_ff <= 7'h00;
            last_odd_ff <= 3'h0;
            act_odd_ff <= 3'h0;
            for (j = 0; j < 6; j = j + 1)
            begin
                cmp_ff[j] <= 16'h0000;
            end
        end
        else if (run)
        begin
            if (counter_clear_i)
            begin
                // counter and prescaler only
                cnt_ff <= `BPT_CNT_RST;
                pre_ff <= 7'h00;
            end
            else if (go)
            begin
                pre_ff <= pre_ff + 7'h01;
                if (step)
                begin
                    cnt_ff <= wrap ? `BPT_CNT_RST : cnt_ff + 16'h0001;
                end
            end
            if (cmp_wr_i & acc & (cmp_ch_i < 3'h6))
            begin
                cmp_ff[cmp_ch_i] <= cmp_data_i;
                // record which set of the pair was written last
                last_odd_ff[cmp_ch_i[2:1]] <= cmp_ch_i[0];
            end
            for (j = 0; j < 3; j = j + 1)
            begin
                if (~buffer_link_select_i[2 * j])
                begin
                    // unlinked pair restarts on the even set
                    act_odd_ff[j] <= 1'b0;
                    last_odd_ff[j] <= 1'b0;
                end
                else if (wrap)
                begin
                    // new set only takes over at a period start
                    act_odd_ff[j] <= last_odd_ff[j];
                end
            end
        end
    end

    //------------------------------------------------------------
    // channel pins
    //------------------------------------------------------------
    always @(posedge clk_sys_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            pin_ff <= 6'h00;
        end
        else if (run)
        begin
            for (k = 0; k < 6; k = k + 1)
            begin
                if (out_mode[k])
                begin
                    if (toggle_on_wrap_i[k] & full_duty_select_i[k])
                    begin
                        // constant pulse level
                        pin_ff[k] <= ~edge_level_select_i[2 * k];
                    end
                    else if (match[k] & edge_level_select_i[2 * k + 1])
                    begin
                        // compare drives the complement of the pulse level
                        pin_ff[k] <= edge_level_select_i[2 * k];
                    end
                    else if (match[k] & (edge_level_select_i[2 * k +: 2] == `BPT_ELS_TOGGLE))
                    begin
                        pin_ff[k] <= ~pin_ff[k];
                    end
                    else if (wrap & toggle_on_wrap_i[k])
                    begin
                        // no toggle when the wrap toggle is off
                        pin_ff[k] <= ~pin_ff[k];
                    end
                end
            end
        end
    end

    //------------------------------------------------------------
    // flags: set wins over clear, clear needs read first
    //------------------------------------------------------------
    always @(posedge clk_sys_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            wrap_flag_ff <= 1'b0;
            wrap_arm_ff <= 1'b0;
            ch_flag_ff <= 6'h00;
            ch_arm_ff <= 6'h00;
            mod_lock_ff <= 1'b0;
        end
        else if (run)
        begin
            if (modulo_wr_i & acc)
            begin
                mod_lock_ff <= ~mod_lock_ff; // two bytes: high then low
            end
            if (wrap & ~mod_lock_ff)
            begin
                wrap_flag_ff <= 1'b1;
                wrap_arm_ff <= 1'b0; // a new wrap spoils an armed clear
            end
            else if (wrap_flag_clr_i & wrap_arm_ff & clr_ok)
            begin
                wrap_flag_ff <= 1'b0;
                wrap_arm_ff <= 1'b0;
            end
            else if (wrap_flag_rd_i & wrap_flag_ff & acc)
            begin
                wrap_arm_ff <= 1'b1;
            end
            for (m = 0; m < 6; m = m + 1)
            begin
                if (match[m] & out_mode[m])
                begin
                    ch_flag_ff[m] <= 1'b1;
                    ch_arm_ff[m] <= 1'b0;
                end
                else if (ch_flag_clr_i[m] & ch_arm_ff[m] & clr_ok)
                begin
                    ch_flag_ff[m] <= 1'b0;
                    ch_arm_ff[m] <= 1'b0;
                end
                else if (ch_flag_rd_i[m] & ch_flag_ff[m] & acc)
                begin
                    ch_arm_ff[m] <= 1'b1;
                end
            end
        end
    end

    //------------------------------------------------------------
    // outputs
    //------------------------------------------------------------
    assign counter_o = cnt_ff;
    assign counter_wrap_flag_o = wrap_flag_ff;
    assign channel_event_flag_o = ch_flag_ff;
    assign channel_pin_o = pin_ff;
    assign channel_pin_oe_o = out_mode; // odd pin released when linked
    assign active_set_o = act_odd_ff;
    assign irq_o = (wrap_flag_ff & wrap_irq_enable_i) |
                   (|(ch_flag_ff & channel_irq_enable_i));
    assign wake_o = irq_o & wait_mode_i;

endmodule

/* sim/bpt_timer_assertions.sv */
// concurrent checks on the ports of the buffered pwm timer
`timescale 1ns/1ps
module bpt_timer_chk
(
    // clock and reset
    input wire clk_sys_i,
    input wire rstn_i,
    // watched controls
    input wire clk_en_i,
    input wire wait_mode_i,
    input wire stop_mode_i,
    input wire break_active_i,
    input wire counter_halt_i,
    input wire counter_clear_i,
    input wire [2:0] prescale_sel_i,
    input wire wrap_irq_enable_i,
    input wire [15:0] modulo_value_i,
    input wire [5:0] buffer_link_select_i,
    input wire [5:0] unbuffered_mode_select_i,
    input wire [11:0] edge_level_select_i,
    input wire [5:0] toggle_on_wrap_i,
    input wire [5:0] full_duty_select_i,
    input wire [5:0] channel_irq_enable_i,
    // watched outputs
    input wire [15:0] counter_o,
    input wire counter_wrap_flag_o,
    input wire [5:0] channel_pin_o,
    input wire [5:0] channel_pin_oe_o,
    input wire irq_o,
    input wire wake_o
);
    // --------------------------------------------------------------
    // helpers: one clock domain, so default clocking and disable
    // --------------------------------------------------------------
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rstn_i);
    // run: the block takes this edge at all
    wire run = clk_en_i && !stop_mode_i;
    // tick: only divide-by-one is modelled here, other rates stay unchecked
    wire tick = run && !counter_halt_i && !break_active_i && prescale_sel_i == 3'h0
        && !counter_clear_i;
    chk_wrap_restart: assert property (tick && counter_o == modulo_value_i |=> counter_o == 16'h0000)
        else $error("counter did not restart after the period end");
    chk_wrap_flag_set: assert property (tick && counter_o == modulo_value_i |=> counter_wrap_flag_o)
        else $error("wrap flag not set at the period end");
    chk_clear_zero: assert property (run && !wait_mode_i && counter_clear_i |=> counter_o == 16'h0000)
        else $error("counter clear did not zero the counter");
    chk_break_halt: assert property (run && break_active_i && !counter_clear_i |=> $stable(counter_o))
        else $error("counter moved during a debug break");
    chk_stop_freeze: assert property (stop_mode_i |=> $stable(counter_o) && $stable(channel_pin_o) && $stable(counter_wrap_flag_o))
        else $error("state changed in stop mode");
    chk_link_pins: assert property (buffer_link_select_i[2] |-> !channel_pin_oe_o[3] && channel_pin_oe_o[2])
        else $error("linked pair pin enables wrong");
    chk_wake_gate: assert property (wake_o == (irq_o && wait_mode_i))
        else $error("wake request does not follow interrupt in wait");
    chk_wrap_irq: assert property (counter_wrap_flag_o && wrap_irq_enable_i |-> irq_o)
        else $error("enabled wrap flag gave no interrupt");
    chk_irq_masked: assert property (!wrap_irq_enable_i && channel_irq_enable_i == 6'h00 |-> !irq_o)
        else $error("interrupt raised with all enables off");
    chk_zero_duty: assert property (run && unbuffered_mode_select_i[4] && !buffer_link_select_i[4] && !toggle_on_wrap_i[4] && !full_duty_select_i[4] && edge_level_select_i[9:8] == 2'h2 && !channel_pin_o[4] |=> !channel_pin_o[4])
        else $error("pin left zero duty without wrap toggle");
    chk_full_duty: assert property (run && unbuffered_mode_select_i[1] && !buffer_link_select_i[0] && toggle_on_wrap_i[1] && full_duty_select_i[1] && edge_level_select_i[3:2] == 2'h2 |=> channel_pin_o[1])
        else $error("full duty channel not held at pulse level");
endmodule
bind bpt_timer bpt_timer_chk bpt_timer_chk_inst (.*);

/* sim/bpt_timer_tb_top.sv */
// self-checking bench for the buffered pwm timer block
`timescale 1ns/1ps
`include "bpt_regs.vh"
`define BPT_CHK(a, b) begin comparisons++; if ((a) !== (b)) begin failures++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, b); end end
module bpt_timer_tb_top;
    // ------------------------------------------------------------------
    // stimulus, all given a value at time zero
    // ------------------------------------------------------------------
    logic clk_sys_i = 1'b0, rstn_i = 1'b0, clk_en_i = 1'b1, wait_mode_i = 1'b0;
    logic stop_mode_i = 1'b0, break_active_i = 1'b0, break_clear_permit_i = 1'b0;
    logic counter_halt_i = 1'b0, counter_clear_i = 1'b0, wrap_irq_enable_i = 1'b0;
    logic [2:0] prescale_sel_i = 3'h0, cmp_ch_i = 3'h0;
    logic [15:0] modulo_value_i = 16'h0000, cmp_data_i = 16'h0000;
    logic modulo_wr_i = 1'b0, wrap_flag_rd_i = 1'b0, wrap_flag_clr_i = 1'b0, cmp_wr_i = 1'b0;
    logic [5:0] buffer_link_select_i = 6'h00, unbuffered_mode_select_i = 6'h00;
    logic [11:0] edge_level_select_i = 12'h000;
    logic [5:0] toggle_on_wrap_i = 6'h00, full_duty_select_i = 6'h00;
    logic [5:0] channel_irq_enable_i = 6'h00, ch_flag_rd_i = 6'h00, ch_flag_clr_i = 6'h00;
    // observed outputs
    wire [15:0] counter_o;
    wire counter_wrap_flag_o, irq_o, wake_o;
    wire [5:0] channel_event_flag_o, channel_pin_o, channel_pin_oe_o;
    wire [2:0] active_set_o;
    int failures = 0, comparisons = 0, cycles = 0;
    logic [4:0] hi [6]; // high cycles per channel over four periods
    bpt_timer bpt_timer_inst (.*);
    // clock of 10 ns
    initial forever #5 clk_sys_i = ~clk_sys_i;
    // ------------------------------------------------------------------
    // tasks; every change lands on a falling edge
    // ------------------------------------------------------------------
    task automatic cyc(input int n);
        repeat (n) @(negedge clk_sys_i);
    endtask
    task automatic pulse(ref logic s);
        s = 1'b1;
        cyc(1);
        s = 1'b0;
    endtask
    task automatic wr_cmp(input logic [2:0] ch, input logic [15:0] d);
        cmp_ch_i = ch;
        cmp_data_i = d;
        pulse(cmp_wr_i);
    endtask
    // bounded wait for the last count, then step past the wrap edge
    task automatic to_wrap;
        repeat (20) if (counter_o !== 16'h0003) cyc(1);
        cyc(1);
    endtask
    // sixteen cycles are four whole periods of modulo 3, any phase
    task automatic duty;
        for (int c = 0; c < 6; c++) hi[c] = 5'h00;
        repeat (16)
        begin
            cyc(1);
            for (int c = 0; c < 6; c++) hi[c] = hi[c] + {4'h0, channel_pin_o[c]};
        end
    endtask
    task automatic final_report;
        $display("comparisons=%0d failures=%0d", comparisons, failures);
        if (failures == 0 && comparisons > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // hang guard: the sequence needs little more than a hundred cycles
    always @(posedge clk_sys_i)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            failures++;
            final_report;
        end
    end
    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial
    begin
        cyc(12);
        rstn_i = 1'b1;
        counter_halt_i = 1'b1; // halt first, then clear, then set up
        pulse(counter_clear_i);
        `BPT_CHK(counter_o, 16'h0000)
        modulo_value_i = 16'h0003;
        pulse(modulo_wr_i);
        cyc(1);
        pulse(modulo_wr_i);
        wr_cmp(3'h0, 16'h0001);
        cyc(1);
        wr_cmp(3'h2, 16'h0001);
        cyc(1);
        wr_cmp(3'h4, 16'h0001);
        // ch0 unbuffered, ch2 both mode bits, ch1 full duty, ch4 no wrap toggle
        unbuffered_mode_select_i = 6'h17;
        buffer_link_select_i = 6'h04;
        edge_level_select_i = {6{`BPT_ELS_CLEAR}}; // never toggle on compare
        toggle_on_wrap_i = 6'h07;
        full_duty_select_i = 6'h02;
        cyc(1);
        `BPT_CHK(active_set_o, 3'h0)
        `BPT_CHK(channel_pin_oe_o[3], 1'b0)
        counter_halt_i = 1'b0;
        cyc(8);
        duty;
        `BPT_CHK(hi[0], 5'h08)
        `BPT_CHK(hi[1], 5'h10)
        `BPT_CHK(hi[2], 5'h08)
        `BPT_CHK(hi[4], 5'h00)
        // odd set written mid-period takes over only at the next wrap
        to_wrap;
        wr_cmp(3'h3, 16'h0002); // inactive set only
        `BPT_CHK(active_set_o[1], 1'b0)
        to_wrap;
        `BPT_CHK(active_set_o[1], 1'b1)
        duty;
        `BPT_CHK(hi[2], 5'h0c)
        to_wrap;
        wr_cmp(3'h2, 16'h0000);
        `BPT_CHK(active_set_o[1], 1'b1)
        to_wrap;
        `BPT_CHK(active_set_o[1], 1'b0)
        duty;
        `BPT_CHK(hi[2], 5'h04)
        // stop and clear while running
        stop_mode_i = 1'b1;
        cyc(5);
        stop_mode_i = 1'b0;
        cyc(2);
        pulse(counter_clear_i);
        `BPT_CHK(counter_o, 16'h0000)
        // flags and interrupts with the counter halted
        counter_halt_i = 1'b1;
        cyc(2);
        `BPT_CHK(counter_wrap_flag_o, 1'b1)
        `BPT_CHK(irq_o, 1'b0)
        wrap_irq_enable_i = 1'b1;
        cyc(1);
        `BPT_CHK(irq_o, 1'b1)
        wait_mode_i = 1'b1;
        cyc(1);
        `BPT_CHK(wake_o, 1'b1)
        pulse(wrap_flag_rd_i);
        pulse(wrap_flag_clr_i);
        `BPT_CHK(counter_wrap_flag_o, 1'b1)
        wait_mode_i = 1'b0;
        pulse(wrap_flag_rd_i);
        break_active_i = 1'b1;
        pulse(wrap_flag_clr_i);
        `BPT_CHK(counter_wrap_flag_o, 1'b1)
        break_active_i = 1'b0;
        cyc(1);
        pulse(wrap_flag_clr_i);
        `BPT_CHK(counter_wrap_flag_o, 1'b0)
        `BPT_CHK(channel_event_flag_o[0], 1'b1)
        wrap_irq_enable_i = 1'b0;
        channel_irq_enable_i = 6'h01;
        cyc(1);
        `BPT_CHK(irq_o, 1'b1)
        // two-step clear of the channel 0 flag with the counter halted
        ch_flag_rd_i = 6'h01;
        cyc(1);
        ch_flag_rd_i = 6'h00;
        ch_flag_clr_i = 6'h01;
        cyc(1);
        ch_flag_clr_i = 6'h00;
        `BPT_CHK(channel_event_flag_o[0], 1'b0)
        `BPT_CHK(irq_o, 1'b0)
        final_report;
    end
endmodule
